// ### include/charge_port_pkg.sv
// constants, modes and carriers for the charging-port mode control block
package charge_port_pkg;
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int SHORT_PULLUP_US = 1000;
    localparam int SHORT_PULLUP_CYC = SHORT_PULLUP_US * CLK_MHZ;
    localparam int HI_TEST_MS = 100;
    localparam int HI_TEST_CYC = HI_TEST_MS * 1000 * CLK_MHZ;
    localparam int FS_MEM_SEC = 60;
    localparam longint FS_MEM_CYC = longint'(FS_MEM_SEC) * 1000000 * CLK_MHZ;
    localparam int DISCHARGE_US = 100;
    localparam int DISCHARGE_CYC = DISCHARGE_US * CLK_MHZ;
    localparam int DEBOUNCE_CYC = 16;
    // control pin codes, order a,b,c,ilim
    localparam logic [3:0] PINS_CDP = 4'hF;
    localparam logic [3:0] PINS_STANDARD_PORT_MODE_TWO = 4'hE;
    localparam logic [2:0] MODE_AUTO_CODE = 3'h3;
    localparam logic [2:0] MODE_CDP_CODE = 3'h7;
    localparam logic [2:0] MODE_SDP1A_CODE = 3'h6;
    localparam logic [2:0] MODE_SDP1B_CODE = 3'h2;

    // decoded port mode
    typedef enum logic [2:0] {
        PM_INIT = 3'b000,
        PM_DISCHARGE = 3'b001,
        PM_AUTO = 3'b010,
        PM_STANDARD = 3'b011,
        PM_FORCED_SHORT = 3'b100,
        PM_FORCED_DIV = 3'b101,
        PM_CDP = 3'b110
    } port_mode_type;

    // data-line signature presented
    typedef enum logic [2:0] {
        SIG_NONE = 3'b000,
        SIG_DIV_LOW = 3'b001,
        SIG_DIV_HIGH = 3'b010,
        SIG_PULLUP = 3'b011,
        SIG_SHORTED = 3'b100
    } signature_type;

    // pins from the host system
    typedef struct packed {
        logic mode_select_pin_a;
        logic mode_select_pin_b;
        logic mode_select_pin_c;
        logic current_limit_choice_pin;
        logic enable;
    } ctrl_pins_type;

    // analog sense results
    typedef struct packed {
        logic dp_high;
        logic dm_high;
        logic bc_device_seen;
        logic line_released;
        logic current_over_750ma;
    } sense_type;
endpackage : charge_port_pkg

// ### hdl/charge_port_ctrl.sv
// mode control logic of a usb charging-port controller
`timescale 1ns/1ps
// What this block does
// - standard or cdp mode closes data switches
// - switches close only with enable high
// - cdp keeps switches closed during handshake
// - open on low enable, 000, dedicated
// - current limit change opens switches except on 111
// - switches open during vbus discharge
// - reset holds initial state, discharging
// - any reset returns to initial
// - after reset go to pin mode
// - discharge: switch off, then back on
// - auto mode starts with divider low
// - bc device: discharge, pullup, then shorted
// - shorted until release, then divider low
// - divider-low device stays divider low
// - over 750ma tries divider high
// - divider signatures drive swapped levels
// - pullup for fixed time, short until release
// - shorted mode joins d+ and d-
// - forced mode holds one scheme
// - hid override keeps standard or cdp on 011
// - data lines stay connected for wake
// - follow commanded mode otherwise
// - no discharge between 1111 and 1110
// - monitor lines only in standard/cdp
// - full speed recorded after 60 s high
module charge_port_ctrl #(
    parameter int PULLUP_CYC = charge_port_pkg::SHORT_PULLUP_CYC,
    parameter int HI_CYC = charge_port_pkg::HI_TEST_CYC,
    parameter longint FS_CYC = charge_port_pkg::FS_MEM_CYC,
    parameter int DIS_CYC = charge_port_pkg::DISCHARGE_CYC,
    parameter int DEB_CYC = charge_port_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host pins and analog sense
    input charge_port_pkg::ctrl_pins_type pins,
    input charge_port_pkg::sense_type sense,
    // outputs
    output logic data_switch_on,
    output logic power_switch_on,
    output logic vbus_discharge,
    output charge_port_pkg::signature_type signature,
    output charge_port_pkg::port_mode_type port_mode,
    output logic hid_override
);
    import charge_port_pkg::*;

    initial begin
        if (PULLUP_CYC < 1 || HI_CYC < 1 || FS_CYC < 1 || DIS_CYC < 1 || DEB_CYC < 2)
            $error("charge_port_ctrl: counts must be positive");
    end

    // ************************************************************
    // pin synchroniser and debounce
    // ************************************************************
    logic [4:0] sync1_r; // first stage
    logic [4:0] sync2_r; // second stage
    logic [4:0] stable_r; // debounced pins
    logic [31:0] deb_cnt_r; // stability counter

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            deb_cnt_r <= 32'h0;
            stable_r <= 5'h00;
        end else if (sync2_r == stable_r) begin
            deb_cnt_r <= 32'h0;
        end else if (deb_cnt_r == 32'(DEB_CYC - 1)) begin
            stable_r <= sync2_r;
            deb_cnt_r <= 32'h0;
        end else begin
            deb_cnt_r <= deb_cnt_r + 32'h1;
        end
    end

    logic [2:0] mode_bits; // a,b,c
    logic [3:0] all_bits; // a,b,c,ilim
    logic en_s; // debounced enable
    assign mode_bits = stable_r[4:2];
    assign all_bits = stable_r[4:1];
    assign en_s = stable_r[0];

    // decode pin code into port mode
    function automatic port_mode_type decode(input logic [3:0] code);
        case (code[3:1])
            3'h0: decode = PM_DISCHARGE;
            3'h1, 3'h3: decode = PM_AUTO;
            3'h2, 3'h6: decode = PM_STANDARD;
            3'h4: decode = PM_FORCED_SHORT;
            3'h5: decode = PM_FORCED_DIV;
            default: decode = code[0] ? PM_CDP : PM_STANDARD;
        endcase
    endfunction : decode

    // ************************************************************
    // hid detection and override
    // ************************************************************
    logic ls_seen_r; // low-speed hid recorded
    logic fs_seen_r; // full-speed hid recorded
    logic [63:0] fs_cnt_r; // d+ high time
    logic monitor; // lines watched
    logic override_now; // pin change overridden
    port_mode_type cmd_mode; // decoded pin mode
    port_mode_type eff_mode; // mode after override
    port_mode_type port_mode_r; // current mode
    logic override_r; // override held
    logic [2:0] last_code_r; // last accepted mode code
    assign cmd_mode = decode(all_bits);
    // watch lines only in data modes
    assign monitor = (port_mode_r == PM_STANDARD) || (port_mode_r == PM_CDP);

    // full speed needs d+ high 60 s
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fs_cnt_r <= 64'h0;
            fs_seen_r <= 1'b0;
            ls_seen_r <= 1'b0;
        end else if (monitor) begin
            if (sense.dm_high && !sense.dp_high) ls_seen_r <= 1'b1;
            if (!sense.dp_high) begin
                fs_cnt_r <= 64'h0;
            end else if (fs_cnt_r == 64'(FS_CYC - 1)) begin
                fs_seen_r <= 1'b1;
            end else begin
                fs_cnt_r <= fs_cnt_r + 64'h1;
            end
        end else if (!override_r) begin
            fs_cnt_r <= 64'h0;
            fs_seen_r <= 1'b0;
            ls_seen_r <= 1'b0;
        end
    end

    // override 111 or 110/010 to 011
    assign override_now = (ls_seen_r || fs_seen_r) && monitor
        && (mode_bits == MODE_AUTO_CODE)
        && (last_code_r == MODE_CDP_CODE || last_code_r == MODE_SDP1A_CODE
            || last_code_r == MODE_SDP1B_CODE);

    // hold connection until pins leave 011
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            override_r <= 1'b0;
        end else if (override_now) begin
            override_r <= 1'b1;
        end else if (mode_bits != MODE_AUTO_CODE) begin
            override_r <= 1'b0;
        end
    end
    assign eff_mode = (override_now || override_r) ? port_mode_r : cmd_mode;

    // ************************************************************
    // mode sequencer with discharge
    // ************************************************************
    logic bc_dis_req; // bc device needs renegotiation
    logic dis_active_r; // discharge running
    logic [31:0] dis_cnt_r; // discharge timer
    logic [3:0] prev_all_r; // pins of current mode
    logic no_dis_pair; // 1111/1110 swap
    assign no_dis_pair = (all_bits == PINS_CDP && prev_all_r == PINS_STANDARD_PORT_MODE_TWO)
        || (all_bits == PINS_STANDARD_PORT_MODE_TWO && prev_all_r == PINS_CDP);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_mode_r <= PM_INIT;
            dis_active_r <= 1'b1;
            dis_cnt_r <= 32'h0;
            prev_all_r <= 4'h0;
            last_code_r <= 3'h0;
        end else if (dis_active_r) begin
            if (dis_cnt_r == 32'(DIS_CYC - 1)) begin
                dis_active_r <= 1'b0;
                dis_cnt_r <= 32'h0;
                port_mode_r <= eff_mode;
                prev_all_r <= all_bits;
                last_code_r <= mode_bits;
            end else begin
                dis_cnt_r <= dis_cnt_r + 32'h1;
            end
        end else if (eff_mode != port_mode_r || (eff_mode == port_mode_r
                     && all_bits != prev_all_r && !override_r && !override_now)) begin
            prev_all_r <= all_bits;
            last_code_r <= mode_bits;
            if (no_dis_pair) begin
                port_mode_r <= eff_mode;
            end else begin
                dis_active_r <= 1'b1;
                port_mode_r <= PM_DISCHARGE;
            end
        end else if (bc_dis_req) begin
            dis_active_r <= 1'b1;
        end
    end

    // ************************************************************
    // auto-detect signature machine
    // ************************************************************
    signature_type auto_sig_r; // auto signature
    logic [31:0] sig_cnt_r; // interval timer
    assign bc_dis_req = (port_mode_r == PM_AUTO) && (auto_sig_r == SIG_DIV_LOW)
        && sense.bc_device_seen;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auto_sig_r <= SIG_DIV_LOW;
            sig_cnt_r <= 32'h0;
        end else if (port_mode_r != PM_AUTO) begin
            auto_sig_r <= SIG_DIV_LOW;
            sig_cnt_r <= 32'h0;
        end else begin
            case (auto_sig_r)
                SIG_DIV_LOW: begin
                    sig_cnt_r <= 32'h0;
                    if (bc_dis_req) auto_sig_r <= SIG_PULLUP;
                    else if (sense.current_over_750ma) auto_sig_r <= SIG_DIV_HIGH;
                end
                SIG_DIV_HIGH: begin
                    if (sig_cnt_r == 32'(HI_CYC - 1)) begin
                        sig_cnt_r <= 32'h0;
                        if (!sense.current_over_750ma) auto_sig_r <= SIG_DIV_LOW;
                    end else begin
                        sig_cnt_r <= sig_cnt_r + 32'h1;
                    end
                end
                SIG_PULLUP: begin
                    if (dis_active_r) begin
                        sig_cnt_r <= 32'h0;
                    end else if (sig_cnt_r == 32'(PULLUP_CYC - 1)) begin
                        sig_cnt_r <= 32'h0;
                        auto_sig_r <= SIG_SHORTED;
                    end else begin
                        sig_cnt_r <= sig_cnt_r + 32'h1;
                    end
                end
                SIG_SHORTED: begin
                    if (sense.line_released) auto_sig_r <= SIG_DIV_LOW;
                end
                default: auto_sig_r <= SIG_DIV_LOW;
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic data_nxt; // data switch next
    signature_type sig_nxt; // signature next

    always_comb begin
        data_nxt = en_s && !dis_active_r
            && (port_mode_r == PM_STANDARD || port_mode_r == PM_CDP);
    end

    always_comb begin
        case (port_mode_r)
            PM_FORCED_SHORT: sig_nxt = SIG_SHORTED;
            PM_FORCED_DIV: sig_nxt = SIG_DIV_LOW;
            PM_AUTO: sig_nxt = dis_active_r ? SIG_NONE : auto_sig_r;
            default: sig_nxt = SIG_NONE;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_switch_on <= 1'b0;
            power_switch_on <= 1'b0;
            vbus_discharge <= 1'b1;
            signature <= SIG_NONE;
            port_mode <= PM_INIT;
            hid_override <= 1'b0;
        end else begin
            data_switch_on <= data_nxt;
            power_switch_on <= !dis_active_r && en_s && port_mode_r != PM_DISCHARGE;
            vbus_discharge <= dis_active_r || port_mode_r == PM_DISCHARGE;
            signature <= sig_nxt;
            port_mode <= port_mode_r;
            hid_override <= override_r;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_sw_dis;
        @(posedge clk) disable iff (!nrst) vbus_discharge |-> !data_switch_on;
    endproperty
    a_sw_dis: assert property (p_sw_dis) else $error("switch on in discharge");

    property p_sw_en;
        @(posedge clk) disable iff (!nrst) !en_s |=> !data_switch_on;
    endproperty
    a_sw_en: assert property (p_sw_en) else $error("switch on with enable low");

    property p_sw_dcp;
        @(posedge clk) disable iff (!nrst)
            (port_mode_r == PM_AUTO || port_mode_r == PM_FORCED_SHORT) |=> !data_switch_on;
    endproperty
    a_sw_dcp: assert property (p_sw_dcp) else $error("switch on in dedicated");

    property p_sw_on;
        @(posedge clk) disable iff (!nrst)
            (en_s && !dis_active_r && port_mode_r == PM_CDP) |=> data_switch_on;
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("switch off in cdp");

    property p_auto_start;
        @(posedge clk) disable iff (!nrst)
            (port_mode_r != PM_AUTO) |=> auto_sig_r == SIG_DIV_LOW;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("auto not at divider low");

    property p_pullup_next;
        @(posedge clk) disable iff (!nrst)
            (auto_sig_r == SIG_PULLUP && port_mode_r == PM_AUTO && $changed(auto_sig_r))
            |-> ##1 auto_sig_r != SIG_SHORTED;
    endproperty
    a_pullup_next: assert property (p_pullup_next) else $error("pullup skipped");

    property p_forced;
        @(posedge clk) disable iff (!nrst)
            (port_mode_r == PM_FORCED_DIV) |=> signature == SIG_DIV_LOW;
    endproperty
    a_forced: assert property (p_forced) else $error("forced divider lost");

    property p_swap;
        @(posedge clk) disable iff (!nrst)
            (!dis_active_r && no_dis_pair && port_mode_r == PM_CDP) |=> !dis_active_r;
    endproperty
    a_swap: assert property (p_swap) else $error("discharge on 1111/1110");

    property p_release;
        @(posedge clk) disable iff (!nrst)
            (port_mode_r == PM_AUTO && auto_sig_r == SIG_SHORTED && sense.line_released)
            |=> auto_sig_r == SIG_DIV_LOW;
    endproperty
    a_release: assert property (p_release) else $error("no return on release");

    c_cdp: cover property (@(posedge clk) data_switch_on && port_mode == PM_CDP);
    c_short: cover property (@(posedge clk) signature == SIG_SHORTED);
    c_high: cover property (@(posedge clk) signature == SIG_DIV_HIGH);
    c_hid: cover property (@(posedge clk) hid_override);
endmodule : charge_port_ctrl

// ### test/portable_device_model.sv
// behavioural portable device standing on the far side of the charging port
`timescale 1ns/1ps
module portable_device_model (
    // what the bench attaches: 0 none, 1 low speed, 2 full speed, 3 bc device
    input wire logic [1:0] kind,
    input wire logic draw_high,
    // port side as seen by the device
    input charge_port_pkg::signature_type signature,
    input wire logic power_switch_on,
    input wire logic vbus_discharge,
    // analog sense results handed to the block
    output charge_port_pkg::sense_type sense
);
    import charge_port_pkg::*;
    logic powered; // vbus present at the device
    // bc answer and heavy draw only while vbus is up, never during discharge
    assign powered = power_switch_on & ~vbus_discharge;
    // low speed idles with d- high, full speed with d+ high
    assign sense.dm_high = (kind == 2'h1);
    assign sense.dp_high = (kind == 2'h2);
    // bc device answers only the divider-low signature
    assign sense.bc_device_seen = powered & (kind == 2'h3) & (signature == SIG_DIV_LOW);
    // lines let go once the bc device leaves
    assign sense.line_released = (kind != 2'h3);
    assign sense.current_over_750ma = powered & draw_high;
endmodule : portable_device_model

// ### test/tb_charge_port_ctrl.sv
// self-checking bench for the charging-port mode control block
`timescale 1ns/1ps
module tb_charge_port_ctrl;
    import charge_port_pkg::*;
    // ****************************************
    // stimulus, outputs and counters
    // ****************************************
    localparam int DIS = 8; // shortened discharge
    localparam int PUL = 6; // shortened pull-up interval
    localparam int HIC = 10; // shortened high-current window
    logic clk = 1'h0;
    logic nrst = 1'h0;
    ctrl_pins_type pins = {PINS_CDP, 1'h1}; // cdp, enabled
    sense_type sense;
    logic [1:0] kind = 2'h0; // attached device kind
    logic draw_high = 1'h0; // device pulls heavy current
    logic data_switch_on, power_switch_on, vbus_discharge, hid_override;
    signature_type signature;
    port_mode_type port_mode;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0; // hang guard
    int n; // cycles a wait took
    always #5 clk = ~clk;
    charge_port_ctrl #(.PULLUP_CYC(PUL), .HI_CYC(HIC), .FS_CYC(20), .DIS_CYC(DIS),
        .DEB_CYC(4)) u_charge_port_ctrl (.clk(clk), .nrst(nrst), .pins(pins),
        .sense(sense), .data_switch_on(data_switch_on), .power_switch_on(power_switch_on),
        .vbus_discharge(vbus_discharge), .signature(signature), .port_mode(port_mode),
        .hid_override(hid_override));
    portable_device_model u_portable_device_model (.kind(kind), .draw_high(draw_high),
        .signature(signature), .power_switch_on(power_switch_on),
        .vbus_discharge(vbus_discharge), .sense(sense));
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // let k edges pass, then settle
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic drive(input logic [2:0] code, input logic ilim, input logic en);
        @(posedge clk);
        #1;
        pins = {code, ilim, en};
    endtask : drive
    // waits on signature (sel high) or port mode, bounded
    task automatic wait_for(input logic sel, input logic [2:0] v, output int k);
        logic [2:0] seen;
        k = 0;
        seen = sel ? 3'(signature) : 3'(port_mode);
        while (seen !== v && k < 300) begin
            step(1);
            k++;
            seen = sel ? 3'(signature) : 3'(port_mode);
        end
        check({5'h0, seen}, {5'h0, v});
    endtask : wait_for
    task automatic summarize;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // discharge must keep data and power switches open
    always @(posedge clk) begin
        if (nrst === 1'h1 && vbus_discharge === 1'h1) begin
            check({6'h0, data_switch_on, power_switch_on}, 8'h00);
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        step(3);
        check({vbus_discharge, power_switch_on, data_switch_on, 2'h0, port_mode},
            {3'h4, 2'h0, PM_INIT});
        step(7);
        nrst = 1'h1;
        wait_for(1'h0, PM_CDP, n);
        step(2);
        check({5'h0, vbus_discharge, power_switch_on, data_switch_on}, 8'h03);
        $display("reset test done");
    endtask : t_reset
    task automatic t_swap;
        drive(3'h7, 1'h0, 1'h1);
        for (int i = 0; i < 40; i++) begin
            step(1);
            check({7'h0, vbus_discharge}, 8'h00);
        end
        check({4'h0, data_switch_on, port_mode}, {4'h1, PM_STANDARD});
        drive(3'h7, 1'h0, 1'h0);
        step(30);
        check({7'h0, data_switch_on}, 8'h00);
        drive(3'h7, 1'h1, 1'h1);
        step(40);
        draw_high = 1'h1;
        step(20);
        check({4'h0, data_switch_on, port_mode}, {4'h1, PM_CDP});
        draw_high = 1'h0;
        $display("swap and enable test done");
    endtask : t_swap
    task automatic t_hid;
        drive(MODE_SDP1B_CODE, 1'h0, 1'h1);
        wait_for(1'h0, PM_STANDARD, n);
        kind = 2'h1;
        step(10);
        drive(MODE_AUTO_CODE, 1'h1, 1'h1);
        for (int i = 0; i < 50 && hid_override !== 1'h1; i++) step(1);
        check({7'h0, hid_override}, 8'h01);
        step(40);
        check({4'h0, data_switch_on, port_mode}, {4'h1, PM_STANDARD});
        kind = 2'h0;
        drive(3'h0, 1'h0, 1'h1);
        step(40);
        check({6'h0, vbus_discharge, data_switch_on}, 8'h02);
        $display("hid override test done");
    endtask : t_hid
    task automatic t_forced;
        for (int i = 0; i < 2; i++) begin
            drive(i ? 3'h5 : 3'h4, 1'h1, 1'h1);
            wait_for(1'h0, i ? PM_FORCED_DIV : PM_FORCED_SHORT, n);
            kind = 2'h3;
            step(30);
            check({2'h0, signature, data_switch_on, power_switch_on, vbus_discharge},
                {2'h0, i ? SIG_DIV_LOW : SIG_SHORTED, 3'h2});
            kind = 2'h0;
        end
        $display("forced mode test done");
    endtask : t_forced
    task automatic t_auto;
        drive(MODE_AUTO_CODE, 1'h0, 1'h1);
        wait_for(1'h0, PM_AUTO, n);
        wait_for(1'h1, SIG_DIV_LOW, n);
        step(20);
        check({4'h0, data_switch_on, signature}, {4'h0, SIG_DIV_LOW});
        kind = 2'h3;
        for (int i = 0; i < 50 && vbus_discharge !== 1'h1; i++) step(1);
        check({vbus_discharge, power_switch_on, 3'h0, signature}, {5'h10, SIG_NONE});
        wait_for(1'h1, SIG_PULLUP, n);
        check({7'h0, power_switch_on}, 8'h01);
        wait_for(1'h1, SIG_SHORTED, n);
        check({7'h0, n >= PUL - 2 && n <= PUL + 2}, 8'h01);
        step(20);
        check({5'h0, signature}, {5'h0, SIG_SHORTED});
        kind = 2'h0;
        wait_for(1'h1, SIG_DIV_LOW, n);
        draw_high = 1'h1;
        wait_for(1'h1, SIG_DIV_HIGH, n);
        draw_high = 1'h0;
        wait_for(1'h1, SIG_DIV_LOW, n);
        draw_high = 1'h1;
        wait_for(1'h1, SIG_DIV_HIGH, n);
        step(HIC + 10);
        check({5'h0, signature}, {5'h0, SIG_DIV_HIGH});
        nrst = 1'h0;
        #2;
        check({vbus_discharge, data_switch_on, 3'h0, port_mode}, {5'h10, PM_INIT});
        draw_high = 1'h0;
        step(2);
        nrst = 1'h1;
        wait_for(1'h0, PM_AUTO, n);
        $display("auto detect test done");
    endtask : t_auto
    initial begin
        t_reset();
        t_swap();
        t_hid();
        t_forced();
        t_auto();
        summarize();
    end
endmodule : tb_charge_port_ctrl
